//--- rtl/epe_engine.sv
// Summary of operation
// [R1] forward bytes sit on data lines, latched by the falling strobe
// [R2] next forward byte waits until busy goes low
// [R3] hostack high for data, low for command bytes in forward
// [R4] peripheral marks reverse commands with periphack low, top bit zero
// [R5] peripheral pulls nack low when reverse data is valid
// [R6] host pulls autofeed low to ask for each reverse byte
// [R7] ninit low selects reverse, high selects forward
// [R8] data lines driven only while nackreverse shows forward
// [R9] falling nfault raises error interrupt, forward direction only
// [R10] nselectin held high throughout ecp mode
// [R11] software clears direction, strobe, autofeed, then sets mode 011
// [R12] address port bytes go as commands, data port bytes as data
// [R13] automatic handshake only in modes 011 and 010
// [R14] mode changes only from 000/001, or back to 000/001
// [R15] direction bit changes only in mode 001
// [R16] software drains fifo before returning to mode 000 or 001
// [R17] run-length count goes to address port, then data byte
// [R18] threshold from config input, fifo disabled after reset
// [R19] dma request follows fifo state, direction and mode
// [R20] terminal count sets service bit, stopping dma requests
// [R21] data port at 400h, address port at 000h, test fifo at 400h
// [R22] programmed i/o clears dma and service bits, irq requests service
// [R23] service bit set on tc or threshold, cleared by software
// [R24] full bit reads one when no free byte remains
// [R25] data drivers released in reverse direction
`timescale 1ns/100ps
`default_nettype none
module epe_engine
    import epe_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // system clock, reset, link clock
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        link_clk,
    // host i/o port
    input  wire logic [10:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    // dma and interrupt
    input  wire logic        dma_ack,
    input  wire logic        dma_tc,
    output logic             port_dma_request,
    output logic             irq,
    // configuration
    input  wire logic [3:0]  fifo_threshold_config,
    // cable side
    input  wire logic [7:0]  pd_in,
    output logic      [7:0]  pd_out,
    output logic             pd_oe_n,
    output logic             nstrobe,
    output logic             nautofd,
    output logic             ninit,
    output logic             nselectin,
    input  wire logic        nack,
    input  wire logic        busy,
    input  wire logic        perror,
    input  wire logic        select,
    input  wire logic        nfault
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    epe_mode_t   mode;
    logic        dir, svc, dma_en, err_en_n;
    logic [3:0]  ctl;
    logic        hs_mode, fifo_on, sw_mode;
    logic        ecr_wr, ctl_wr, wr_a, wr_d, rd_d;
    logic        f_wr_ready, f_rd_valid, f_push, f_pop;
    logic [8:0]  f_wdata, f_rdata;
    logic [CW-1:0] f_count, f_free, thr;
    logic        svc_set, fault_evt, nfault_d;
    logic        fwd_req, fwd_idle, fwd_load, rev_seen, rev_push;
    logic        rev_room;
    logic [8:0]  fwd_word;
    logic [6:0]  c_sync;
    logic        c_busy, c_nack, c_perror, c_select, c_nfault;
    logic        c_fwd_ack, c_rev_req;
    // link domain
    epe_lstate_t st;
    logic [19:0] l_sync;
    logic [7:0]  l_pd;
    logic [3:0]  l_ctl;
    logic        l_dir, l_hs, l_fwd_req, l_rev_ack, l_room;
    logic        l_busy, l_nack, l_perror;
    logic        fwd_seen, rev_req, l_cmd;
    logic [8:0]  rev_word;

    // mode classes
    assign hs_mode = (mode == M_ECP) || (mode == M_PFIFO); // R13
    assign fifo_on = hs_mode || (mode == M_TEST); // R18
    assign sw_mode = (mode == M_SPP) || (mode == M_PS2);

    // address decode of the host port
    always_comb
    begin
        ecr_wr = 1'b0;
        ctl_wr = 1'b0;
        wr_a   = 1'b0;
        wr_d   = 1'b0;
        rd_d   = 1'b0;
        if (dma_ack || io_addr == OFS_DFIFO)
        begin
            wr_d = io_wr && fifo_on && (mode == M_TEST || !dir); // R21
            rd_d = io_rd && fifo_on && (mode == M_TEST || dir); // R21
        end
        else if (io_addr == OFS_AFIFO)
            wr_a = io_wr && (mode == M_ECP) && !dir; // R12
        else if (io_addr == OFS_ECR)
            ecr_wr = io_wr;
        else if (io_addr == OFS_CTRL)
            ctl_wr = io_wr;
    end

    // fifo fill and drain, bit 8 marks a command byte
    assign f_push   = wr_a || wr_d || rev_push;
    assign f_wdata  = rev_push ? rev_word : {wr_a, io_wdata}; // R12 R17
    assign fwd_idle = (fwd_req == c_fwd_ack);
    assign fwd_load = hs_mode && !dir && f_rd_valid && fwd_idle;
    assign f_pop    = rd_d || fwd_load;
    assign f_free   = CW'(DEPTH) - f_count;
    assign thr      = CW'(fifo_threshold_config); // R18

    epe_fifo #(
        .W     (9),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .clk      (clk),
        .rstn     (rstn),
        .flush    (!fifo_on),
        .wr_valid (f_push),
        .wr_data  (f_wdata),
        .wr_ready (f_wr_ready),
        .rd_ready (f_pop),
        .rd_data  (f_rdata),
        .rd_valid (f_rd_valid),
        .count    (f_count)
    );

    // pins and link toggles into the system domain
    epe_sync #(.W(7)) u_csync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({busy, nack, perror, select, nfault, fwd_seen, rev_req}),
        .q    (c_sync)
    );
    assign {c_busy, c_nack, c_perror, c_select, c_nfault,
            c_fwd_ack, c_rev_req} = c_sync;

    // mode field with its switching restriction
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            mode <= RST_MODE;
        else if (ecr_wr && (sw_mode ||
                 io_wdata[ECR_MODE_LO+:3] inside {M_SPP, M_PS2})) // R14
            mode <= epe_mode_t'(io_wdata[ECR_MODE_LO+:3]);
    end

    // dma enable and error enable
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dma_en   <= 1'b0;
            err_en_n <= RST_ERR_N;
        end
        else if (ecr_wr)
        begin
            dma_en   <= io_wdata[ECR_DMA]; // R22
            err_en_n <= io_wdata[ECR_ERR_N];
        end
    end

    // service bit, a hardware set beats a software clear
    assign svc_set = !svc && hs_mode &&
                     (dma_en ? dma_tc // R20
                      : (!dir ? (f_free >= thr) : (f_count >= thr))); // R23
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            svc <= RST_SVC;
        else if (svc_set)
            svc <= 1'b1; // R23
        else if (ecr_wr)
            svc <= io_wdata[ECR_SVC]; // R22
    end

    // control lines and direction
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctl <= '0;
            dir <= RST_DIR;
        end
        else if (ctl_wr)
        begin
            ctl <= io_wdata[3:0];
            if (mode == M_PS2)
                dir <= io_wdata[CTL_DIR]; // R15
        end
    end

    // interrupt: service events and forward faults, cleared by ecr write
    assign fault_evt = nfault_d && !c_nfault && (mode == M_ECP) &&
                       !dir && !err_en_n; // R9
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq      <= 1'b0;
            nfault_d <= 1'b1;
        end
        else
        begin
            nfault_d <= c_nfault;
            if (svc_set || fault_evt)
                irq <= 1'b1; // R22
            else if (ecr_wr)
                irq <= 1'b0;
        end
    end

    // dma request follows direction and fifo level
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            port_dma_request <= 1'b0;
        else
            port_dma_request <= dma_en && !svc && !svc_set && hs_mode &&
                                (dir ? f_rd_valid : f_wr_ready); // R19 R20
    end

    // read data register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            io_rdata <= 8'h00;
        else if (io_rd)
        begin
            if (dma_ack || io_addr == OFS_DFIFO)
                io_rdata <= rd_d && f_rd_valid ? f_rdata[7:0] : 8'h00;
            else if (io_addr == OFS_STAT)
                io_rdata <= {c_busy, c_nack, c_perror, c_select,
                             c_nfault, 3'h0};
            else if (io_addr == OFS_CTRL)
                io_rdata <= {2'h0, dir, 1'b0, ctl};
            else if (io_addr == OFS_ECR)
                io_rdata <= {mode, err_en_n, dma_en, svc,
                             !f_wr_ready, !f_rd_valid}; // R24
            else
                io_rdata <= 8'h00;
        end
    end

    // forward word handed to the link by toggle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fwd_req  <= 1'b0;
            fwd_word <= '0;
        end
        else if (fwd_load)
        begin
            fwd_word <= f_rdata;
            fwd_req  <= !fwd_req;
        end
    end

    // reverse word taken from the link by toggle
    assign rev_push = (c_rev_req != rev_seen) && hs_mode && dir;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rev_seen <= 1'b0;
            rev_room <= 1'b0;
        end
        else
        begin
            rev_seen <= c_rev_req;
            rev_room <= f_free >= CW'(REV_ROOM);
        end
    end

    // everything the link logic reads except fwd_word, on its own clock
    epe_sync #(.W(20)) u_lsync (
        .clk  (link_clk),
        .rstn (rstn),
        .d    ({pd_in, ctl, dir, hs_mode, fwd_req, rev_seen, rev_room,
                busy, nack, perror}),
        .q    (l_sync)
    );
    assign {l_pd, l_ctl, l_dir, l_hs, l_fwd_req, l_rev_ack, l_room,
            l_busy, l_nack, l_perror} = l_sync;

    // link handshake state machine
    always_ff @(posedge link_clk or negedge rstn)
    begin
        if (!rstn)
            st <= L_IDLE;
        else if (!l_hs)
            st <= L_IDLE; // R13
        else
            case (st)
                L_IDLE:
                    if (l_hs && !l_dir && l_fwd_req != fwd_seen && !l_busy)
                        st <= L_FWD_SET; // R2
                    else if (l_hs && l_dir && !l_perror &&
                             rev_req == l_rev_ack && l_room)
                        st <= L_REV_REQ; // R8
                L_FWD_SET: st <= L_FWD_STB;
                L_FWD_STB:
                    if (l_busy)
                        st <= L_FWD_END; // R1
                L_FWD_END: st <= L_IDLE;
                L_REV_REQ:
                    if (!l_nack)
                        st <= L_REV_ACK; // R5
                L_REV_ACK:
                    if (l_nack)
                        st <= L_IDLE;
                default: st <= L_IDLE;
            endcase
    end

    // link-side data capture and toggles
    always_ff @(posedge link_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fwd_seen <= 1'b0;
            rev_req  <= 1'b0;
            rev_word <= '0;
            pd_out   <= 8'h00;
            l_cmd    <= 1'b0;
        end
        else
        begin
            if (st == L_FWD_SET)
            begin
                pd_out <= fwd_word[7:0]; // R1
                l_cmd  <= fwd_word[8];
            end
            if (st == L_FWD_END || !l_hs) // aborted byte counts as taken
                fwd_seen <= l_fwd_req;
            if (st == L_REV_REQ && !l_nack)
            begin
                rev_word <= {!l_busy, l_pd}; // R4
                rev_req  <= !rev_req;
            end
        end
    end

    // cable control lines
    always_ff @(posedge link_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nstrobe   <= 1'b1;
            nautofd   <= 1'b1;
            ninit     <= 1'b1;
            nselectin <= 1'b1;
            pd_oe_n   <= 1'b1;
        end
        else if (l_hs)
        begin
            nstrobe   <= (st != L_FWD_STB); // R1
            nautofd   <= l_dir ? (st != L_REV_REQ) // R6
                       : (st == L_FWD_SET) ? !fwd_word[8] // R3
                       : !(st != L_IDLE && l_cmd); // R3
            ninit     <= !l_dir; // R7
            nselectin <= 1'b1; // R10
            pd_oe_n   <= l_dir || !l_perror; // R8 R25
        end
        else
        begin
            nstrobe   <= !l_ctl[CTL_STROBE];
            nautofd   <= !l_ctl[CTL_AUTOFD];
            ninit     <= l_ctl[CTL_INIT];
            nselectin <= !l_ctl[CTL_SELIN];
            pd_oe_n   <= l_dir; // R25
        end
    end

    // strobe falls only after the byte has been set up
    sequence s_fwd_setup;
        st == L_FWD_SET ##1 st == L_FWD_STB;
    endsequence
    AST_STROBE_AFTER_DATA: assert property (@(posedge link_clk) // R1
        disable iff (!rstn) s_fwd_setup |=> !nstrobe && $stable(pd_out))
        else $error("strobe not asserted over stable data");
    AST_WAIT_NOT_BUSY: assert property (@(posedge link_clk) // R2
        disable iff (!rstn) st == L_FWD_SET |-> $past(!l_busy))
        else $error("byte started while peripheral busy");
    AST_HOSTACK_CMD: assert property (@(posedge link_clk) // R3
        disable iff (!rstn)
        (l_hs && !l_dir && st == L_FWD_STB) [*2] |-> nautofd == !l_cmd)
        else $error("hostack does not match byte type");
    AST_REV_REQUEST: assert property (@(posedge link_clk) // R6
        disable iff (!rstn)
        l_hs && l_dir && st == L_REV_REQ |=> !nautofd)
        else $error("no autofeed request in reverse");
    AST_NINIT_DIR: assert property (@(posedge link_clk) // R7
        disable iff (!rstn) l_hs |=> ninit == !$past(l_dir))
        else $error("ninit does not follow direction");
    AST_RELEASE_REV: assert property (@(posedge link_clk) // R25
        disable iff (!rstn) l_dir ##1 l_dir |-> pd_oe_n)
        else $error("data lines driven in reverse");
    AST_SELIN_HIGH: assert property (@(posedge link_clk) // R10
        disable iff (!rstn) l_hs |=> nselectin)
        else $error("nselectin low in ecp mode");
    AST_MODE_LOCK: assert property (@(posedge clk) // R14
        disable iff (!rstn) ecr_wr && !sw_mode &&
        !(io_wdata[ECR_MODE_LO+:3] inside {M_SPP, M_PS2})
        |=> mode == $past(mode))
        else $error("illegal mode change accepted");
    AST_DIR_LOCK: assert property (@(posedge clk) // R15
        disable iff (!rstn) mode != M_PS2 |=> dir == $past(dir))
        else $error("direction changed outside mode 001");
    AST_TC_STOPS_DMA: assert property (@(posedge clk) // R20
        disable iff (!rstn)
        dma_en && hs_mode && dma_tc && !svc |=> svc ##1 !port_dma_request)
        else $error("terminal count did not stop dma");
    AST_FULL_BIT: assert property (@(posedge clk) // R24
        disable iff (!rstn) io_rd && io_addr == OFS_ECR
        |=> io_rdata[ECR_FULL] == ($past(f_count) == CW'(DEPTH)))
        else $error("full bit wrong");
endmodule
`default_nettype wire

//--- rtl/epe_pkg.sv
package epe_pkg;
    // port offsets on the host i/o port
    localparam logic [10:0] OFS_AFIFO = 11'h000;
    localparam logic [10:0] OFS_STAT  = 11'h001;
    localparam logic [10:0] OFS_CTRL  = 11'h002;
    localparam logic [10:0] OFS_DFIFO = 11'h400;
    localparam logic [10:0] OFS_ECR   = 11'h402;

    // port modes held in the mode field
    typedef enum logic [2:0] {
        M_SPP   = 3'h0,
        M_PS2   = 3'h1,
        M_PFIFO = 3'h2,
        M_ECP   = 3'h3,
        M_TEST  = 3'h6,
        M_CFG   = 3'h7
    } epe_mode_t;

    // link-side handshake states, gray along the forward path
    typedef enum logic [2:0] {
        L_IDLE    = 3'h0,
        L_FWD_SET = 3'h1,
        L_FWD_STB = 3'h3,
        L_FWD_END = 3'h2,
        L_REV_REQ = 3'h4,
        L_REV_ACK = 3'h5
    } epe_lstate_t;

    // field positions of the control and extended control registers
    localparam int CTL_STROBE  = 0;
    localparam int CTL_AUTOFD  = 1;
    localparam int CTL_INIT    = 2;
    localparam int CTL_SELIN   = 3;
    localparam int CTL_DIR     = 5;
    localparam int ECR_EMPTY   = 0;
    localparam int ECR_FULL    = 1;
    localparam int ECR_SVC     = 2;
    localparam int ECR_DMA     = 3;
    localparam int ECR_ERR_N   = 4;
    localparam int ECR_MODE_LO = 5;

    // reset values
    localparam epe_mode_t RST_MODE = M_SPP;
    localparam logic RST_SVC   = 1'h1;
    localparam logic RST_ERR_N = 1'h1;
    localparam logic RST_DIR   = 1'h0;

    // least free space kept before the link is allowed another byte
    localparam int REV_ROOM = 2;
endpackage

//--- rtl/epe_sync.sv
`timescale 1ns/100ps
`default_nettype none
module epe_sync #(
    parameter int W = 1
) (
    // clock and reset of the receiving domain
    input  wire logic         clk,
    input  wire logic         rstn,
    // level in and synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // two flops, the first read only by the second
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

//--- rtl/epe_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module epe_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          flush,
    // fill side
    input  wire logic          wr_valid,
    input  wire logic [W-1:0]  wr_data,
    output logic               wr_ready,
    // drain side
    input  wire logic          rd_ready,
    output logic [W-1:0]       rd_data,
    output logic               rd_valid,
    output logic [AW:0]        count
);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic          push;
    logic          pop;

    // honest full and empty from the fill count
    assign wr_ready = (count != (AW+1)'(DEPTH));
    assign rd_valid = (count != '0);
    assign push     = wr_valid && wr_ready;
    assign pop      = rd_ready && rd_valid;
    assign rd_data  = mem[rptr];

    // storage
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wptr] <= wr_data;
    end

    // pointers and count, cleared while disabled
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end
        else if (flush)
        begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
            if (pop)
                rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

//--- verification/epe_periph_model.sv
`timescale 1ns/100ps
`default_nettype none
module epe_periph_model (
    // cable lines from the host
    input  wire logic       link_clk,
    input  wire logic [7:0] pd_out,
    input  wire logic       pd_oe_n,
    input  wire logic       nstrobe,
    input  wire logic       nautofd,
    input  wire logic       ninit,
    input  wire logic       fault_req,
    // cable lines from the peripheral
    output logic      [7:0] pd_in,
    output logic            nack,
    output logic            busy,
    output logic            perror,
    output logic            select,
    output logic            nfault
);
    logic [8:0] cap[8];
    logic [8:0] rev[4];
    logic [7:0] drv;
    int         cap_n;
    int         rev_n;
    int         rev_i;
    // host wins when enabled, else our byte or its stale inverse
    assign pd_in  = pd_oe_n ? drv : pd_out;
    assign select = 1'h1;
    assign nfault = !fault_req;
    initial
    begin
        busy = 1'h0;
        nack = 1'h1;
        perror = 1'h1;
        drv = 8'h5a;
        cap_n = 0;
        rev_n = 0;
        rev_i = 0;
    end
    // turnaround ack follows the reverse request a link clock late
    always @(posedge link_clk)
        perror <= ninit;
    // forward: take byte and mode on falling strobe, release busy slowly
    always @(negedge nstrobe)
    begin
        cap[cap_n] = {nautofd, pd_out};
        cap_n++;
        busy = 1'h1;
        @(posedge nstrobe);
        repeat (3) @(posedge link_clk);
        busy <= 1'h0;
    end
    // reverse: one queued byte for each autofeed request
    always @(negedge nautofd)
    begin
        if (!ninit && rev_i < rev_n)
        begin
            drv = rev[rev_i][7:0];
            busy = rev[rev_i][8];
            @(posedge link_clk);
            nack <= 1'h0;
            @(posedge nautofd);
            nack = 1'h1;
            rev_i++;
            @(posedge link_clk);
            drv <= ~drv;
        end
    end
endmodule
`default_nettype wire

//--- verification/epe_engine_tb.sv
`timescale 1ns/100ps
`default_nettype none
module epe_engine_tb
    import epe_pkg::*;
;
    // bench-driven lines
    logic        clk = 1'h0;
    logic        link_clk = 1'h0;
    logic        rstn = 1'h0;
    logic [10:0] io_addr = 11'h000;
    logic        io_wr = 1'h0;
    logic        io_rd = 1'h0;
    logic [7:0]  io_wdata = 8'h00;
    logic        dma_tc = 1'h0;
    logic        dma_ack = 1'h0;
    logic        fault_req = 1'h0;
    // design and model outputs
    logic [7:0]  io_rdata, pd_in, pd_out, rd_q;
    logic        port_dma_request, irq, pd_oe_n, nstrobe, nautofd;
    logic        ninit, nselectin, nack, busy, perror, select, nfault;
    int          error_cnt = 0;
    int          n_compared = 0;
    always #4 clk = ~clk;
    // link clock phase kept off the system clock edges
    initial
    begin
        #2.5;
        forever #80 link_clk = ~link_clk;
    end
    epe_engine #(.DEPTH(16)) dut_u (
        .clk(clk), .rstn(rstn), .link_clk(link_clk),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata),
        .dma_ack(dma_ack), .dma_tc(dma_tc),
        .port_dma_request(port_dma_request), .irq(irq),
        .fifo_threshold_config(4'h2),
        .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(pd_oe_n),
        .nstrobe(nstrobe), .nautofd(nautofd), .ninit(ninit),
        .nselectin(nselectin), .nack(nack), .busy(busy),
        .perror(perror), .select(select), .nfault(nfault));
    epe_periph_model pm_u (
        .link_clk(link_clk), .pd_out(pd_out), .pd_oe_n(pd_oe_n),
        .nstrobe(nstrobe), .nautofd(nautofd), .ninit(ninit),
        .fault_req(fault_req), .pd_in(pd_in), .nack(nack),
        .busy(busy), .perror(perror), .select(select),
        .nfault(nfault));
    // compare one value
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one host write, one host read
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'h1;
        @(negedge clk);
        io_wr = 1'h0;
    endtask
    task automatic rd(input logic [10:0] a);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'h1;
        @(negedge clk);
        io_rd = 1'h0;
        rd_q = io_rdata;
    endtask
    task automatic conclude();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_reset();
        rd(OFS_ECR);
        chk(rd_q, 8'h15);
        chk(port_dma_request, 1'h0);
        repeat (80) @(negedge clk);
        chk(nselectin, 1'h1);
        $display("t_reset done");
    endtask
    task automatic t_mode();
        wr(OFS_ECR, 8'h64);
        wr(OFS_ECR, 8'hc4);
        rd(OFS_ECR);
        chk(rd_q, 8'h65);
        wr(OFS_CTRL, 8'h20);
        rd(OFS_CTRL);
        chk(rd_q[5], 1'h0);
        wr(OFS_ECR, 8'h24);
        wr(OFS_CTRL, 8'h20);
        rd(OFS_CTRL);
        chk(rd_q[5], 1'h1);
        wr(OFS_CTRL, 8'h00);
        wr(OFS_ECR, 8'h04);
        $display("t_mode done");
    endtask
    task automatic t_fwd();
        logic [8:0] exp[3];
        exp = '{9'h085, 9'h1a5, 9'h13c};
        wr(OFS_DFIFO, 8'h99);
        wr(OFS_ECR, 8'h64);
        wr(OFS_AFIFO, 8'h85);
        wr(OFS_DFIFO, 8'ha5);
        wr(OFS_DFIFO, 8'h3c);
        for (int i = 0; i < 8000 && pm_u.cap_n < 3; i++)
            @(negedge clk);
        repeat (200) @(negedge clk);
        chk(pm_u.cap_n[8:0], 9'h003);
        for (int i = 0; i < 3; i++)
            chk(pm_u.cap[i], exp[i]);
        chk(nselectin, 1'h1);
        $display("t_fwd done");
    endtask
    task automatic t_rev();
        pm_u.rev[0] = 9'h1c3;
        pm_u.rev[1] = 9'h012;
        pm_u.rev_n = 2;
        wr(OFS_ECR, 8'h24);
        wr(OFS_CTRL, 8'h20);
        wr(OFS_ECR, 8'h64);
        for (int i = 0; i < 8000 && pm_u.rev_i < 2; i++)
            @(negedge clk);
        repeat (100) @(negedge clk);
        chk(ninit, 1'h0);
        chk(pd_oe_n, 1'h1);
        wr(OFS_ECR, 8'h60);
        repeat (3) @(negedge clk);
        chk(irq, 1'h1);
        rd(OFS_DFIFO);
        chk(rd_q, 8'hc3);
        rd(OFS_DFIFO);
        chk(rd_q, 8'h12);
        rd(OFS_ECR);
        chk(rd_q, 8'h65);
        wr(OFS_ECR, 8'h24);
        wr(OFS_CTRL, 8'h00);
        wr(OFS_ECR, 8'h04);
        $display("t_rev done");
    endtask
    task automatic t_dma();
        wr(OFS_ECR, 8'h48);
        repeat (4) @(negedge clk);
        chk(port_dma_request, 1'h1);
        chk(irq, 1'h0);
        dma_tc = 1'h1;
        @(negedge clk);
        dma_tc = 1'h0;
        repeat (2) @(negedge clk);
        chk(port_dma_request, 1'h0);
        chk(irq, 1'h1);
        rd(OFS_ECR);
        chk(rd_q[2], 1'h1);
        wr(OFS_ECR, 8'h04);
        $display("t_dma done");
    endtask
    task automatic t_fault();
        wr(OFS_ECR, 8'h64);
        chk(irq, 1'h0);
        fault_req = 1'h1;
        repeat (20) @(negedge clk);
        chk(irq, 1'h1);
        fault_req = 1'h0;
        wr(OFS_ECR, 8'h04);
        $display("t_fault done");
    endtask
    task automatic t_full();
        wr(OFS_ECR, 8'hc4);
        for (int i = 0; i < 17; i++)
            wr(OFS_DFIFO, 8'h40 + 8'(i));
        rd(OFS_ECR);
        chk(rd_q, 8'hc6);
        for (int i = 0; i < 16; i++)
        begin
            dma_ack = (i == 15);
            rd(dma_ack ? 11'h7ff : OFS_DFIFO);
            chk(rd_q, 8'h40 + 8'(i));
        end
        dma_ack = 1'h0;
        rd(OFS_ECR);
        chk(rd_q, 8'hc5);
        rd(11'h7ff);
        chk(rd_q, 8'h00);
        $display("t_full done");
    endtask
    // watchdog sized well past the expected run
    initial
    begin
        #500000;
        error_cnt++;
        conclude();
    end
    initial
    begin
        repeat (10) @(negedge clk);
        repeat (3) @(posedge link_clk);
        @(negedge clk);
        rstn = 1'h1;
        t_reset();
        t_mode();
        t_fwd();
        t_rev();
        t_dma();
        t_fault();
        t_full();
        conclude();
    end
endmodule
`default_nettype wire
